// ===== pkg/i2c_seq_regs.vh
// constants shared by the two-wire transmit sequencer files
`ifndef I2C_SEQ_REGS_VH
`define I2C_SEQ_REGS_VH

// own wishbone registers (byte offsets)
`define REG_CTRL 6'h00
`define REG_FRAME 6'h04
`define REG_COUNT 6'h08
`define REG_DIVIDER 6'h0c
`define REG_IRQ_STATUS 6'h10
`define REG_IRQ_MASK 6'h14
`define TXBUF_BASE_BIT 5

// ctrl fields
`define CTRL_GO_BIT 0
`define CTRL_BUSY_BIT 1
`define CTRL_NACK_BIT 2

// irq status fields
`define IRQ_DONE_BIT 0
`define IRQ_NACK_BIT 1
`define IRQ_WIDTH 2

// device register indices on the device port
`define DEV_DATA 3'h0
`define DEV_OUT_LEVELS 3'h1
`define DEV_OUT_ENABLE 3'h2
`define DEV_START 3'h3
`define DEV_STATUS 3'h4
`define DEV_IRQ_CLEAR 3'h5

// device field positions and values
`define OUT_LEVELS_IDLE 16'h0f0f
`define DATA_LEVEL_BIT 0
`define CLOCK_LEVEL_BIT 8
`define CHANNEL_BIT 0
`define DIVIDER_LSB 9
`define DIVIDER_WIDTH 7
`define ACK_ERROR_BIT 0
`define RESET_DIVIDER 7'h01

// timing
`define CLK_MHZ 200
`define HOLD_TIME_NS 4000
`define HOLD_CYCLES ((`HOLD_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== rtl/level_sync.v
// two flip-flop synchroniser for a level from outside the clock domain
module level_sync (
	input wire core_clk,
	input wire sys_rst,
	input wire async_in,
	output reg sync_out
);
	reg meta_reg;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			meta_reg <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ===== rtl/tx_byte_mem.v
// small byte store for the data frames, registered read
module tx_byte_mem #(
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire core_clk,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [7:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [7:0] rd_data
);
	reg [7:0] mem [0:DEPTH-1];

	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ===== rtl/i2c_tx_sequencer.v
// controller that drives the serial channel through an address+data write
`include "i2c_seq_regs.vh"
module i2c_tx_sequencer #(
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire core_clk,
	input wire sys_rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output wire irq,
	output reg [2:0] dev_addr,
	output reg [15:0] dev_wdata,
	output reg dev_we,
	output reg dev_re,
	input wire [15:0] dev_rdata,
	input wire transfer_end_irq,
	input wire bus_clock_line
);
	localparam S_IDLE = 18'h00001;
	localparam S_WAIT_HIGH = 18'h00002;
	localparam S_SO_LOW = 18'h00004;
	localparam S_HOLD = 18'h00008;
	localparam S_CKO_LOW = 18'h00010;
	localparam S_WAIT_LOW = 18'h00020;
	localparam S_SOE_ON = 18'h00040;
	localparam S_SS_ON = 18'h00080;
	localparam S_FETCH = 18'h00100;
	localparam S_LOAD = 18'h00200;
	localparam S_WAIT_END = 18'h00400;
	localparam S_CLR_END = 18'h00800;
	localparam S_RD_ST = 18'h01000;
	localparam S_CHECK = 18'h02000;
	localparam S_STOP_SOE = 18'h04000;
	localparam S_STOP_SO = 18'h08000;
	localparam S_STOP_HOLD = 18'h10000;
	localparam S_STOP_REL = 18'h20000;
	localparam integer HOLD_INT = `HOLD_CYCLES - 1;
	localparam [11:0] HOLD_LAST = HOLD_INT[11:0];

	reg [17:0] state_reg;
	reg [7:0] frame_reg;
	reg [AW:0] count_reg;
	reg [`DIVIDER_WIDTH-1:0] divider_reg;
	reg [`DIVIDER_WIDTH-1:0] run_div_reg;
	reg [`IRQ_WIDTH-1:0] irq_status_reg;
	reg [`IRQ_WIDTH-1:0] irq_mask_reg;
	reg [AW:0] sent_reg;
	reg [11:0] hold_cnt_reg;
	reg addr_phase_reg;
	reg nack_reg;
	reg end_prev_reg;
	reg go_pulse;
	reg done_evt;
	reg nack_evt;
	wire scl_sync;
	wire end_sync;
	wire wb_hit;
	wire buf_wr;
	wire [7:0] mem_rdata;
	wire busy;
	wire end_rise;

	// drives the out-levels register with chosen clock and data bits
	function [15:0] out_levels;
		input clk_bit;
		input data_bit;
		reg [15:0] v;
		begin
			v = `OUT_LEVELS_IDLE;
			v[`CLOCK_LEVEL_BIT] = clk_bit;
			v[`DATA_LEVEL_BIT] = data_bit;
			out_levels = v;
		end
	endfunction

	// divider in 15:9, byte in 7:0, bit 8 zero
	function [15:0] data_word;
		input [`DIVIDER_WIDTH-1:0] div;
		input [7:0] byte_val;
		begin
			data_word = {div, 1'b0, byte_val};
		end
	endfunction

	level_sync scl_sync_i (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(bus_clock_line),
		.sync_out(scl_sync)
	);

	level_sync end_sync_i (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(transfer_end_irq),
		.sync_out(end_sync)
	);

	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign buf_wr = wb_hit & wb_we_i & wb_sel_i[0] & wb_adr_i[`TXBUF_BASE_BIT];
	assign busy = ~state_reg[0];
	assign end_rise = end_sync & ~end_prev_reg;
	assign irq = |(irq_status_reg & irq_mask_reg);

	tx_byte_mem #(
		.DEPTH(DEPTH),
		.AW(AW)
	) buf_i (
		.core_clk(core_clk),
		.wr_en(buf_wr),
		.wr_addr(wb_adr_i[AW+1:2]),
		.wr_data(wb_dat_i[7:0]),
		.rd_addr(sent_reg[AW-1:0]),
		.rd_data(mem_rdata)
	);

	// wishbone slave: ack one cycle after the request, dropped next cycle
	always @(posedge core_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			go_pulse <= 1'b0;
			frame_reg <= 8'h00;
			count_reg <= {(AW+1){1'b0}};
			divider_reg <= `RESET_DIVIDER;
			irq_mask_reg <= {`IRQ_WIDTH{1'b0}};
		end else begin
			wb_ack_o <= wb_hit;
			go_pulse <= 1'b0;
			wb_dat_o <= 32'h00000000;
			if (wb_hit & wb_we_i & ~wb_adr_i[`TXBUF_BASE_BIT]) begin
				case (wb_adr_i)
				`REG_CTRL: begin
					go_pulse <= wb_sel_i[0] & wb_dat_i[`CTRL_GO_BIT] & ~busy;
				end
				`REG_FRAME: begin
					// address in 7:1, direction in bit 0
					if (wb_sel_i[0] & ~busy) frame_reg <= wb_dat_i[7:0];
				end
				`REG_COUNT: begin
					if (wb_sel_i[0] & ~busy) count_reg <= wb_dat_i[AW:0];
				end
				`REG_DIVIDER: begin
					// zero would exceed a quarter of the channel clock
					if (wb_sel_i[0] & ~busy) begin
						if (wb_dat_i[`DIVIDER_WIDTH-1:0] == 7'h00) begin
							divider_reg <= 7'h01;
						end else begin
							divider_reg <= wb_dat_i[`DIVIDER_WIDTH-1:0];
						end
					end
				end
				`REG_IRQ_MASK: begin
					if (wb_sel_i[0]) irq_mask_reg <= wb_dat_i[`IRQ_WIDTH-1:0];
				end
				default: begin
				end
				endcase
			end
			if (wb_hit & ~wb_we_i) begin
				case (wb_adr_i)
				`REG_CTRL: begin
					wb_dat_o[`CTRL_BUSY_BIT] <= busy;
					wb_dat_o[`CTRL_NACK_BIT] <= nack_reg;
				end
				`REG_FRAME: wb_dat_o[7:0] <= frame_reg;
				`REG_COUNT: wb_dat_o[AW:0] <= count_reg;
				`REG_DIVIDER: wb_dat_o[`DIVIDER_WIDTH-1:0] <= divider_reg;
				`REG_IRQ_STATUS: wb_dat_o[`IRQ_WIDTH-1:0] <= irq_status_reg;
				`REG_IRQ_MASK: wb_dat_o[`IRQ_WIDTH-1:0] <= irq_mask_reg;
				default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// sticky events; a new event wins over a same-cycle write-one clear
	always @(posedge core_clk) begin
		if (sys_rst) begin
			irq_status_reg <= {`IRQ_WIDTH{1'b0}};
		end else begin
			if (wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `REG_IRQ_STATUS)) begin
				irq_status_reg <= (irq_status_reg & ~wb_dat_i[`IRQ_WIDTH-1:0])
					| {nack_evt, done_evt};
			end else begin
				irq_status_reg <= irq_status_reg | {nack_evt, done_evt};
			end
		end
	end

	// sequencer over the device port
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= S_IDLE;
			dev_addr <= `DEV_DATA;
			dev_wdata <= 16'h0000;
			dev_we <= 1'b0;
			dev_re <= 1'b0;
			run_div_reg <= `RESET_DIVIDER;
			sent_reg <= {(AW+1){1'b0}};
			hold_cnt_reg <= 12'h000;
			addr_phase_reg <= 1'b0;
			nack_reg <= 1'b0;
			end_prev_reg <= 1'b1; // synchroniser resets high: no false edge
			done_evt <= 1'b0;
			nack_evt <= 1'b0;
		end else begin
			dev_we <= 1'b0;
			dev_re <= 1'b0;
			done_evt <= 1'b0;
			nack_evt <= 1'b0;
			end_prev_reg <= end_sync;
			case (state_reg)
			S_IDLE: begin
				if (go_pulse) begin
					run_div_reg <= divider_reg;
					sent_reg <= {(AW+1){1'b0}};
					nack_reg <= 1'b0;
					state_reg <= S_WAIT_HIGH;
				end
			end
			S_WAIT_HIGH: begin
				if (scl_sync) state_reg <= S_SO_LOW;
			end
			S_SO_LOW: begin
				// output enable still off, so the level bit owns the line
				dev_addr <= `DEV_OUT_LEVELS;
				dev_wdata <= out_levels(1'b1, 1'b0);
				dev_we <= 1'b1;
				hold_cnt_reg <= 12'h000;
				state_reg <= S_HOLD;
			end
			S_HOLD: begin
				hold_cnt_reg <= hold_cnt_reg + 12'h001;
				if (hold_cnt_reg == HOLD_LAST) state_reg <= S_CKO_LOW;
			end
			S_CKO_LOW: begin
				dev_addr <= `DEV_OUT_LEVELS;
				dev_wdata <= out_levels(1'b0, 1'b0);
				dev_we <= 1'b1;
				state_reg <= S_WAIT_LOW;
			end
			S_WAIT_LOW: begin
				if (~scl_sync) state_reg <= S_SOE_ON;
			end
			S_SOE_ON: begin
				dev_addr <= `DEV_OUT_ENABLE;
				dev_wdata <= 16'h0001 << `CHANNEL_BIT;
				dev_we <= 1'b1;
				state_reg <= S_SS_ON;
			end
			S_SS_ON: begin
				dev_addr <= `DEV_START;
				dev_wdata <= 16'h0001 << `CHANNEL_BIT;
				dev_we <= 1'b1;
				addr_phase_reg <= 1'b1;
				state_reg <= S_LOAD;
			end
			S_FETCH: begin
				// one cycle for the registered buffer read
				state_reg <= S_LOAD;
			end
			S_LOAD: begin
				// divider rewritten unchanged with every frame
				dev_addr <= `DEV_DATA;
				if (addr_phase_reg) begin
					dev_wdata <= data_word(run_div_reg, frame_reg);
				end else begin
					dev_wdata <= data_word(run_div_reg, mem_rdata);
				end
				dev_we <= 1'b1;
				state_reg <= S_WAIT_END;
			end
			S_WAIT_END: begin
				// device holds clock low until the next byte is written
				if (end_rise) state_reg <= S_CLR_END;
			end
			S_CLR_END: begin
				dev_addr <= `DEV_IRQ_CLEAR;
				dev_wdata <= 16'h0001 << `CHANNEL_BIT;
				dev_we <= 1'b1;
				state_reg <= S_RD_ST;
			end
			S_RD_ST: begin
				// ack flag valid once the end interrupt is seen
				dev_addr <= `DEV_STATUS;
				dev_re <= 1'b1;
				state_reg <= S_CHECK;
			end
			S_CHECK: begin
				if (~dev_re) begin
					if (dev_rdata[`ACK_ERROR_BIT]) begin
						nack_reg <= 1'b1;
						nack_evt <= 1'b1;
						state_reg <= S_STOP_SOE;
					end else begin
						if (~addr_phase_reg) sent_reg <= sent_reg + 1'b1;
						addr_phase_reg <= 1'b0;
						if ((addr_phase_reg ? sent_reg : sent_reg + 1'b1)
							== count_reg) begin
							state_reg <= S_STOP_SOE;
						end else begin
							state_reg <= S_FETCH;
						end
					end
				end
			end
			S_STOP_SOE: begin
				// output enable only touched once no frame is in flight
				dev_addr <= `DEV_OUT_ENABLE;
				dev_wdata <= 16'h0000;
				dev_we <= 1'b1;
				state_reg <= S_STOP_SO;
			end
			S_STOP_SO: begin
				dev_addr <= `DEV_OUT_LEVELS;
				dev_wdata <= out_levels(1'b1, 1'b0);
				dev_we <= 1'b1;
				hold_cnt_reg <= 12'h000;
				state_reg <= S_STOP_HOLD;
			end
			S_STOP_HOLD: begin
				hold_cnt_reg <= hold_cnt_reg + 12'h001;
				if (hold_cnt_reg == HOLD_LAST) state_reg <= S_STOP_REL;
			end
			S_STOP_REL: begin
				// data rises while clock high, line left at idle high
				dev_addr <= `DEV_OUT_LEVELS;
				dev_wdata <= out_levels(1'b1, 1'b1);
				dev_we <= 1'b1;
				done_evt <= 1'b1;
				state_reg <= S_IDLE;
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== bench/i2c_tx_sequencer_properties.sv
// checker for the sequencer's bus and device-port sequencing
`include "i2c_seq_regs.vh"
module i2c_tx_sequencer_properties (
	input wire core_clk,
	input wire sys_rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire [31:0] wb_dat_o,
	input wire irq,
	input wire [2:0] dev_addr,
	input wire [15:0] dev_wdata,
	input wire dev_we,
	input wire dev_re,
	input wire transfer_end_irq,
	input wire bus_clock_line
);
timeunit 1ns;
timeprecision 1ps;
logic in_frame;
logic en_q;
logic go_q;
int hold_cnt;
wire dw = dev_we && dev_addr == `DEV_DATA;
wire so_w = dev_we && dev_addr == `DEV_OUT_LEVELS;
wire lo_w = so_w && dev_wdata[8] && !dev_wdata[0];
// saturating, so a long idle never wraps into a false short hold
always @(posedge core_clk) begin
	if (sys_rst || lo_w)
		hold_cnt <= 0;
	else if (hold_cnt < 900)
		hold_cnt <= hold_cnt + 1;
	if (sys_rst || transfer_end_irq)
		in_frame <= 0;
	else if (dw)
		in_frame <= 1;
	if (sys_rst)
		en_q <= 0;
	else if (dev_we && dev_addr == `DEV_OUT_ENABLE)
		en_q <= dev_wdata[0];
	if (sys_rst)
		go_q <= 0;
	else if (dev_we && dev_addr == `DEV_START)
		go_q <= dev_wdata[0];
end
default clocking cb @(posedge core_clk); endclocking
default disable iff (sys_rst);
AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
	else $error("bus request not answered next cycle");
AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 0)
	else $error("read data not zero outside ack");
AST_START_IDLE: assert property (lo_w |-> !en_q)
	else $error("start level written with output enabled");
AST_HOLD: assert property (so_w && !lo_w |-> hold_cnt >= 799)
	else $error("clock hold time too short");
AST_EN_LOW: assert property (dev_we && dev_addr == `DEV_OUT_ENABLE &&
	dev_wdata[0] |-> !bus_clock_line)
	else $error("output enabled while clock high");
AST_DATA_GO: assert property (dw |-> go_q && en_q)
	else $error("byte loaded before channel start");
AST_DATA_FORM: assert property (dw |-> dev_wdata[15:9] != 0 &&
	!dev_wdata[8])
	else $error("data word divider field bad");
AST_QUIET: assert property (in_frame |-> !dev_we)
	else $error("device written during a frame");
AST_CLEAR: assert property ($rose(transfer_end_irq) |->
	##[1:20] (dev_we && dev_addr == `DEV_IRQ_CLEAR))
	else $error("frame end flag not cleared");
AST_STATUS: assert property (dev_re |-> dev_addr == `DEV_STATUS)
	else $error("read of other than status");
COV_END: cover property ($rose(transfer_end_irq));
COV_IRQ: cover property ($rose(irq));
COV_STOP: cover property (lo_w && hold_cnt > 100);
endmodule
bind i2c_tx_sequencer i2c_tx_sequencer_properties chk_i (.*);

// ===== bench/serial_channel_model.sv
// behavioural serial channel driven through the device port
`include "i2c_seq_regs.vh"
module serial_channel_model (
	input wire core_clk,
	input wire sys_rst,
	input wire [2:0] dev_addr,
	input wire [15:0] dev_wdata,
	input wire dev_we,
	input wire dev_re,
	input wire nack,
	output logic [15:0] dev_rdata,
	output logic transfer_end_irq,
	output logic bus_clock_line,
	output logic frame_v,
	output logic [7:0] frame_byte,
	output logic [6:0] frame_div
);
timeunit 1ns;
timeprecision 1ps;
logic started;
logic ack_err;
logic re_q;
logic ph = 1'b0;
int half;
int cnt;
// status only valid around a read; otherwise the bus churns
assign dev_rdata = (dev_re || re_q) ? {15'h0, ack_err} : {16{ph}};
always @(posedge core_clk) begin
	ph <= ~ph;
	re_q <= dev_re;
	frame_v <= 0;
	if (sys_rst) begin
		bus_clock_line <= 1;
		started <= 0;
		transfer_end_irq <= 0;
		ack_err <= 0;
		half <= 0;
	end else if (half != 0) begin
		// half period div+1 cycles keeps the rate at most a quarter
		cnt <= (cnt == frame_div) ? 0 : cnt + 1;
		if (cnt == frame_div) begin
			bus_clock_line <= ~bus_clock_line;
			half <= half - 1;
		end
		// eight bits plus one acknowledge period, no parity
		if (cnt == frame_div && half == 1) begin
			transfer_end_irq <= 1;
			ack_err <= nack;
			frame_v <= 1;
		end
	end else if (dev_we) begin
		if (dev_addr == `DEV_OUT_LEVELS)
			bus_clock_line <= dev_wdata[8];
		if (dev_addr == `DEV_START)
			started <= dev_wdata[0];
		if (dev_addr == `DEV_IRQ_CLEAR && dev_wdata[0])
			transfer_end_irq <= 0;
		// clock stays low until a byte arrives
		if (dev_addr == `DEV_DATA && started) begin
			frame_byte <= dev_wdata[7:0];
			frame_div <= dev_wdata[15:9];
			half <= 18;
			cnt <= 0;
		end
	end
end
endmodule

// ===== bench/test_i2c_tx_sequencer.sv
// self-checking bench for the two-wire transmit sequencer
`include "i2c_seq_regs.vh"
module test_i2c_tx_sequencer;
timeunit 1ns;
timeprecision 1ps;
logic core_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, nack = 0;
logic [5:0] adr = 0;
logic [31:0] dat = 0, q;
wire [31:0] dout;
wire ack, irq, dwe, dre, tei, scl, fv;
wire [2:0] da;
wire [15:0] dwd, drd;
wire [7:0] fb;
wire [6:0] fd;
int num_errors = 0, n_compared = 0, nk = -1, dv = 1;
int tn[6] = '{2, 8, 0, 3, 4, 5};
int tk[6] = '{-1, -1, -1, 0, 2, 5};
logic [7:0] got[$], exp[$];
always #2.5 core_clk = ~core_clk;
i2c_tx_sequencer dut (.core_clk(core_clk), .sys_rst(sys_rst),
	.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
	.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
	.irq(irq), .dev_addr(da), .dev_wdata(dwd), .dev_we(dwe), .dev_re(dre),
	.dev_rdata(drd), .transfer_end_irq(tei), .bus_clock_line(scl));
serial_channel_model chan (.core_clk(core_clk), .sys_rst(sys_rst),
	.dev_addr(da), .dev_wdata(dwd), .dev_we(dwe), .dev_re(dre),
	.nack(nack), .dev_rdata(drd), .transfer_end_irq(tei),
	.bus_clock_line(scl), .frame_v(fv), .frame_byte(fb), .frame_div(fd));
task chk(input logic [31:0] s, input logic [31:0] e);
	n_compared++;
	if (s !== e) begin
		num_errors++;
		$display("unexpected at %0t: seen %h expected %h", $time, s, e);
	end
endtask
task conclude;
	$display("compared %0d mismatches %0d", n_compared, num_errors);
	if (num_errors == 0 && n_compared > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
always @(posedge core_clk) begin
	nack <= (got.size() == nk);
	if (fv) begin
		got.push_back(fb);
		chk(fd, dv);
	end
end
task wb(input logic [5:0] a, input logic w, input logic [31:0] d);
	int i;
	cyc <= 1;
	stb <= 1;
	we <= w;
	adr <= a;
	dat <= d;
	i = 0;
	do begin
		@(posedge core_clk);
		i++;
	end while (ack !== 1'b1 && i < 20);
	q = dout;
	if (ack !== 1'b1) begin
		num_errors++;
		conclude;
	end
	cyc <= 0;
	stb <= 0;
	@(posedge core_clk);
endtask
task run(input int n, input int k);
	int i;
	int m;
	int st;
	exp = {8'($urandom)};
	got = {};
	nk = k;
	wb(`REG_FRAME, 1, exp[0]);
	wb(`REG_COUNT, 1, n);
	for (i = 0; i < n; i++) begin
		exp.push_back($urandom);
		wb(6'(32 + 4 * i), 1, exp[i + 1]);
	end
	m = $urandom % 4;
	wb(`REG_IRQ_MASK, 1, m);
	wb(`REG_CTRL, 1, 1);
	i = 0;
	do begin
		wb(`REG_CTRL, 0, 0);
		i++;
	end while (q[1] !== 1'b0 && i < 3000);
	if (q[1] !== 1'b0) begin
		num_errors++;
		conclude;
	end
	// the stop path always raises done, a nack run adds the nack bit
	st = (k >= 0) ? 3 : 1;
	if (k >= 0)
		exp = exp[0:k];
	chk(q[2], st[1]);
	chk(got.size(), exp.size());
	foreach (exp[j]) chk(got[j], exp[j]);
	wb(`REG_IRQ_STATUS, 0, 0);
	chk(q, st);
	chk(irq, |(st & m));
	wb(`REG_IRQ_STATUS, 1, 3);
	chk(irq, 0);
	chk(scl, 1);
	$display("run done bytes %0d nack at %0d", n, k);
endtask
initial begin
	void'($urandom(62570));
	repeat (8) @(posedge core_clk);
	sys_rst <= 0;
	@(posedge core_clk);
	wb(`REG_DIVIDER, 0, 0);
	chk(q, 1);
	wb(`REG_IRQ_MASK, 0, 0);
	chk(q, 0);
	wb(6'h18, 1, 32'hffffffff);
	wb(6'h18, 0, 0);
	chk(q, 0);
	wb(`REG_DIVIDER, 1, 0);
	wb(`REG_DIVIDER, 0, 0);
	chk(q, 1);
	$display("register test done");
	for (int r = 0; r < 6; r++) begin
		dv = 1 + $urandom % 8;
		wb(`REG_DIVIDER, 1, dv);
		run(tn[r], tk[r]);
	end
	conclude;
end
endmodule
